//--- src/pdors_regs.vh
/*
 pdors_regs.vh: register offsets, field positions, reset values and timing
 counts for the PDO refresh scheduler.
 Assumes inclusion by bare name from the scheduler's design files.
*/
`ifndef PDORS_REGS_VH
`define PDORS_REGS_VH

// =====================================================================
// register byte offsets (APB, one aligned word each)
`define PDORS_OFF_CTRL     12'h000
`define PDORS_OFF_SYNC     12'h004
`define PDORS_OFF_RATE     12'h008
`define PDORS_OFF_TMO      12'h00C
`define PDORS_OFF_RETRY    12'h010
`define PDORS_OFF_RECON    12'h014
`define PDORS_OFF_STATUS   12'h018
`define PDORS_OFF_IRQ_STAT 12'h01C
`define PDORS_OFF_IRQ_MASK 12'h020
`define PDORS_OFF_COUNT    12'h024
`define PDORS_OFF_PDO_CNT  12'h028
`define PDORS_OFF_LINK     12'h02C

// =====================================================================
// field positions
`define PDORS_CTRL_SYNC_BIT   0
`define PDORS_CTRL_ENABLE_BIT 1
`define PDORS_LINK_UP_BIT     0
`define PDORS_LINK_DOWN_BIT   1
`define PDORS_IRQ_SENT_BIT    0
`define PDORS_IRQ_SUPP_BIT    1
`define PDORS_IRQ_TMO_BIT     2
`define PDORS_IRQ_FAIL_BIT    3
`define PDORS_IRQ_RECON_BIT   4

// =====================================================================
// bit rate codes
`define PDORS_RATE_20K  3'h0
`define PDORS_RATE_50K  3'h1
`define PDORS_RATE_125K 3'h2
`define PDORS_RATE_250K 3'h3
`define PDORS_RATE_500K 3'h4
`define PDORS_RATE_1M   3'h5

// =====================================================================
// reset values and timeout maximum
`define PDORS_CTRL_RST  2'h3
`define PDORS_SYNC_RST  32'h0000_2710
`define PDORS_RATE_RST  3'h2
`define PDORS_TMO_RST   12'h064
`define PDORS_TMO_MAX   12'hBB8
`define PDORS_RETRY_RST 8'h3C
`define PDORS_RECON_RST 8'h3C

// =====================================================================
// timing: tick lengths in time units and derived cycle counts at 100 MHz
`define PDORS_CLK_HZ      100000000
`define PDORS_US_NS       1000
`define PDORS_MS_US       1000
`define PDORS_S_MS        1000
`define PDORS_US_CYCLES   ((`PDORS_US_NS * (`PDORS_CLK_HZ / 1000000)) / 1000)

`endif

//--- src/pdors_tick.v
/*
 pdors_tick.v: free running tick divider, one-cycle pulse every DIV clocks.
 Assumes a single clock with synchronous active low reset.
*/
module pdors_tick #(
   parameter DIV = 1000
) (
   input wire clk,
   input wire rst_b,
   output reg tick
);
   reg [31:0] cnt;

   always @(posedge clk) begin
      if (!rst_b) begin
         cnt <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (cnt >= DIV - 1) begin
         cnt <= 32'h0000_0000;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 32'h0000_0001;
         tick <= 1'b0;
      end
   end
endmodule

//--- src/pdors_link.v
/*
 pdors_link.v: communication timeout, retry and automatic reconnect sequencer.
 Assumes ms_tick and s_tick pulses from the same clock domain and a
 one-cycle rx_ok pulse for each good exchange with the slaves.
*/
module pdors_link (
   input wire clk,
   input wire rst_b,
   input wire ms_tick,
   input wire s_tick,
   input wire rx_ok,
   input wire [11:0] tmo_ms,
   input wire [7:0] retry_max,
   input wire [7:0] recon_s,
   output reg link_up,
   output reg retry_req,
   output reg timeout_ev,
   output reg fail_ev,
   output reg recon_ev
);
   localparam ST_UP = 2'h0;
   localparam ST_RETRY = 2'h1;
   localparam ST_DOWN = 2'h2;

   reg [1:0] state;
   reg [11:0] ms_cnt;
   reg [7:0] tries;
   reg [7:0] s_cnt;

   always @(posedge clk) begin
      if (!rst_b) begin
         state <= ST_UP;
         ms_cnt <= 12'h000;
         tries <= 8'h00;
         s_cnt <= 8'h00;
         link_up <= 1'b1;
         retry_req <= 1'b0;
         timeout_ev <= 1'b0;
         fail_ev <= 1'b0;
         recon_ev <= 1'b0;
      end else begin
         retry_req <= 1'b0;
         timeout_ev <= 1'b0;
         fail_ev <= 1'b0;
         recon_ev <= 1'b0;
         case (state)
            ST_UP: begin
               // a zero timeout disables supervision
               if (rx_ok || tmo_ms == 12'h000) begin
                  ms_cnt <= 12'h000;
               end else if (ms_tick) begin
                  if (ms_cnt + 12'h001 >= tmo_ms) begin
                     ms_cnt <= 12'h000;
                     timeout_ev <= 1'b1;
                     tries <= 8'h00;
                     state <= ST_RETRY;
                  end else begin
                     ms_cnt <= ms_cnt + 12'h001;
                  end
               end
            end
            ST_RETRY: begin
               if (rx_ok) begin
                  state <= ST_UP;
                  link_up <= 1'b1;
               end else if (tries >= retry_max) begin
                  state <= ST_DOWN;
                  link_up <= 1'b0;
                  fail_ev <= 1'b1;
                  s_cnt <= 8'h00;
               end else if (ms_tick) begin
                  if (ms_cnt + 12'h001 >= tmo_ms) begin
                     ms_cnt <= 12'h000;
                     tries <= tries + 8'h01;
                     retry_req <= 1'b1;
                  end else begin
                     ms_cnt <= ms_cnt + 12'h001;
                  end
               end
            end
            default: begin
               if (rx_ok) begin
                  state <= ST_UP;
                  link_up <= 1'b1;
                  ms_cnt <= 12'h000;
               end else if (recon_s != 8'h00 && s_tick) begin
                  if (s_cnt + 8'h01 >= recon_s) begin
                     s_cnt <= 8'h00;
                     retry_req <= 1'b1;
                     recon_ev <= 1'b1;
                  end else begin
                     s_cnt <= s_cnt + 8'h01;
                  end
               end
            end
         endcase
      end
   end
endmodule

//--- src/pdors_top.v
/*
 pdors_top.v: PDO refresh scheduler with APB register file and interrupt.
 Assumes scan_end, sync_start and data_changed come from controller logic
 on clk; can_rx comes from the bus transceiver pin.
*/
// The implementer's own choices: the register offsets and the APB register port.
// Behaviour
// - sync mode: count restarts each sync cycle
// - scan end, count over half: send, clear
// - below half or already sent: suppress, keep counting
// - new cycle, none sent, past half: send
// - async mode: send at scan end if changed
// - dominant is 0, recessive is 1
// - bit rate default 125k, selectable
// - timeout 0 to 3000 ms, default 100
// - retries 0 to 255, default 60
// - reconnect interval 0 to 255 s, default 60
// - bit rates limited to six values
`include "pdors_regs.vh"

module pdors_top (
   input wire clk,
   input wire rst_b,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire scan_end,
   input wire sync_start,
   input wire data_changed,
   input wire rx_ok,
   input wire can_rx,
   output reg pdo_send,
   output reg retry_req,
   output reg [2:0] rate_sel,
   output reg bus_dominant,
   output wire link_up,
   output reg irq
);
   // =====================================================================
   // registers
   reg sync_mode;
   reg enable;
   reg [31:0] sync_us;
   reg [11:0] tmo_ms;
   reg [7:0] retry_max;
   reg [7:0] recon_s;
   reg [4:0] irq_stat;
   reg [4:0] irq_mask;
   reg [31:0] elapsed;
   reg sent_in_cycle;
   reg [15:0] pdo_cnt;
   reg can_rx_m;
   reg can_rx_s;
   reg [31:0] next_elapsed;
   reg next_send;
   reg next_sent;
   reg next_supp;

   wire us_tick;
   wire ms_tick;
   wire s_tick;
   wire timeout_ev;
   wire fail_ev;
   wire recon_ev;
   wire link_retry;
   wire wr_en;
   wire rd_en;
   wire addr_ok;
   wire past_half;
   wire rate_wr_ok;
   wire [11:0] tmo_wr_val;
   reg [4:0] irq_clr;
   reg [4:0] irq_set;
   reg [4:0] next_irq_stat;
   // reset word split per field so each flop takes exactly one bit
   wire [1:0] ctrl_rst = `PDORS_CTRL_RST;

   // bit rate code legal only for the six supported rates
   function rate_ok;
      input [2:0] code;
      begin
         rate_ok = (code <= `PDORS_RATE_1M);
      end
   endfunction

   // exactly half still waits: the compare against this is strict
   function [31:0] half_of;
      input [31:0] t;
      begin
         half_of = {1'b0, t[31:1]}; // rounded down
      end
   endfunction

   // =====================================================================
   // time bases
   pdors_tick #(.DIV(`PDORS_US_CYCLES)) u_us (
      .clk(clk),
      .rst_b(rst_b),
      .tick(us_tick)
   );

   // ms and s ticks counted from the us tick keeps dividers narrow
   reg [9:0] us_div;
   reg [9:0] ms_div;
   reg ms_pulse;
   reg s_pulse;
   assign ms_tick = ms_pulse;
   assign s_tick = s_pulse;

   always @(posedge clk) begin
      if (!rst_b) begin
         us_div <= 10'h000;
         ms_div <= 10'h000;
         ms_pulse <= 1'b0;
         s_pulse <= 1'b0;
      end else begin
         ms_pulse <= 1'b0;
         s_pulse <= 1'b0;
         if (us_tick) begin
            if (us_div == `PDORS_MS_US - 1) begin
               us_div <= 10'h000;
               ms_pulse <= 1'b1;
               if (ms_div == `PDORS_S_MS - 1) begin
                  ms_div <= 10'h000;
                  s_pulse <= 1'b1;
               end else begin
                  ms_div <= ms_div + 10'h001;
               end
            end else begin
               us_div <= us_div + 10'h001;
            end
         end
      end
   end

   // =====================================================================
   // link supervision
   pdors_link u_link (
      .clk(clk),
      .rst_b(rst_b),
      .ms_tick(ms_tick),
      .s_tick(s_tick),
      .rx_ok(rx_ok),
      .tmo_ms(tmo_ms),
      .retry_max(retry_max),
      .recon_s(recon_s),
      .link_up(link_up),
      .retry_req(link_retry),
      .timeout_ev(timeout_ev),
      .fail_ev(fail_ev),
      .recon_ev(recon_ev)
   );

   // =====================================================================
   // bus level sampling
   // the pin is asynchronous to clk: two flops before any logic reads it
   always @(posedge clk) begin
      if (!rst_b) begin
         can_rx_m <= 1'b1;
         can_rx_s <= 1'b1;
         bus_dominant <= 1'b0;
         retry_req <= 1'b0;
      end else begin
         can_rx_m <= can_rx;
         can_rx_s <= can_rx_m;
         bus_dominant <= ~can_rx_s;
         retry_req <= link_retry;
      end
   end

   // =====================================================================
   // send decision
   assign past_half = elapsed > half_of(sync_us);

   always @* begin
      next_elapsed = elapsed;
      next_send = 1'b0;
      next_sent = sent_in_cycle;
      next_supp = 1'b0;
      if (us_tick) begin
         next_elapsed = elapsed + 32'h0000_0001;
      end
      if (!enable) begin
         next_elapsed = 32'h0000_0000;
         next_sent = 1'b0;
      end else if (sync_mode) begin
         // a cycle start takes priority over a scan end in the same clock
         if (sync_start) begin
            next_sent = 1'b0;
            if (!sent_in_cycle && past_half) begin
               next_send = 1'b1;
            end
            // count restarts at every cycle start either way
            next_elapsed = 32'h0000_0000;
         end else if (scan_end) begin
            if (past_half && !sent_in_cycle) begin
               next_send = 1'b1;
               next_sent = 1'b1;
               next_elapsed = 32'h0000_0000;
            end else begin
               next_supp = 1'b1;
            end
         end
      end else if (scan_end) begin
         // scan period regularity is the operator's job
         if (data_changed) begin
            next_send = 1'b1;
         end else begin
            next_supp = 1'b1;
         end
      end
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         elapsed <= 32'h0000_0000;
         sent_in_cycle <= 1'b0;
         pdo_send <= 1'b0;
         pdo_cnt <= 16'h0000;
      end else begin
         elapsed <= next_elapsed;
         sent_in_cycle <= next_sent;
         pdo_send <= next_send;
         // wraps at the top; software works with differences
         if (next_send) begin
            pdo_cnt <= pdo_cnt + 16'h0001;
         end
      end
   end

   // =====================================================================
   // APB slave, zero wait states
   assign pready = 1'b1;
   assign addr_ok = (paddr <= `PDORS_OFF_LINK) && (paddr[1:0] == 2'b00);
   assign pslverr = psel && penable && !addr_ok;
   assign wr_en = psel && penable && pwrite && addr_ok;
   assign rd_en = psel && penable && !pwrite;
   // a rate word is legal only with all upper bits clear
   assign rate_wr_ok = (pwdata[31:3] == 29'h0000000) && rate_ok(pwdata[2:0]);
   // out of range timeouts are clamped to the maximum
   assign tmo_wr_val = (pwdata > {20'h00000, `PDORS_TMO_MAX}) ? `PDORS_TMO_MAX : pwdata[11:0];

   // =====================================================================
   // configuration registers
   always @(posedge clk) begin
      if (!rst_b) begin
         sync_mode <= ctrl_rst[`PDORS_CTRL_SYNC_BIT];
         enable <= ctrl_rst[`PDORS_CTRL_ENABLE_BIT];
         sync_us <= `PDORS_SYNC_RST;
         rate_sel <= `PDORS_RATE_RST;
         tmo_ms <= `PDORS_TMO_RST;
         retry_max <= `PDORS_RETRY_RST;
         recon_s <= `PDORS_RECON_RST;
         irq_mask <= 5'h00;
      end else begin
         if (wr_en) begin
            if (paddr == `PDORS_OFF_CTRL) begin
               sync_mode <= pwdata[`PDORS_CTRL_SYNC_BIT];
               enable <= pwdata[`PDORS_CTRL_ENABLE_BIT];
            end else if (paddr == `PDORS_OFF_SYNC) begin
               sync_us <= pwdata;
            end else if (paddr == `PDORS_OFF_RATE) begin
               if (rate_wr_ok) begin
                  rate_sel <= pwdata[2:0];
               end
            end else if (paddr == `PDORS_OFF_TMO) begin
               tmo_ms <= tmo_wr_val;
            end else if (paddr == `PDORS_OFF_RETRY) begin
               retry_max <= pwdata[7:0];
            end else if (paddr == `PDORS_OFF_RECON) begin
               recon_s <= pwdata[7:0];
            end else if (paddr == `PDORS_OFF_IRQ_MASK) begin
               irq_mask <= pwdata[4:0];
            end
         end
      end
   end

   // =====================================================================
   // interrupt status
   // hardware set wins over a simultaneous write-one clear
   always @* begin
      irq_clr = 5'h00;
      if (wr_en && paddr == `PDORS_OFF_IRQ_STAT) begin
         irq_clr = pwdata[4:0];
      end
      irq_set = {recon_ev, fail_ev, timeout_ev, next_supp, next_send};
      next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         irq_stat <= 5'h00;
         irq <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         irq <= |(irq_stat & irq_mask);
      end
   end

   // =====================================================================
   // read mux, zero outside a read access
   always @* begin
      prdata = 32'h0000_0000;
      if (rd_en) begin
         if (paddr == `PDORS_OFF_CTRL) begin
            prdata = {30'h0000_0000, enable, sync_mode};
         end else if (paddr == `PDORS_OFF_SYNC) begin
            prdata = sync_us;
         end else if (paddr == `PDORS_OFF_RATE) begin
            prdata = {29'h0000_0000, rate_sel};
         end else if (paddr == `PDORS_OFF_TMO) begin
            prdata = {20'h00000, tmo_ms};
         end else if (paddr == `PDORS_OFF_RETRY) begin
            prdata = {24'h000000, retry_max};
         end else if (paddr == `PDORS_OFF_RECON) begin
            prdata = {24'h000000, recon_s};
         end else if (paddr == `PDORS_OFF_STATUS) begin
            prdata = {29'h0000_0000, bus_dominant, past_half, sent_in_cycle};
         end else if (paddr == `PDORS_OFF_IRQ_STAT) begin
            prdata = {27'h0000000, irq_stat};
         end else if (paddr == `PDORS_OFF_IRQ_MASK) begin
            prdata = {27'h0000000, irq_mask};
         end else if (paddr == `PDORS_OFF_COUNT) begin
            prdata = elapsed;
         end else if (paddr == `PDORS_OFF_PDO_CNT) begin
            prdata = {16'h0000, pdo_cnt};
         end else if (paddr == `PDORS_OFF_LINK) begin
            prdata = {31'h0000_0000, link_up};
         end
      end
   end
endmodule

//--- verif/pdors_asserts.sv
/* pdors_asserts.sv: port checker for the PDO refresh scheduler.
   Assumes a bind onto pdors_top; one clock, synchronous reset. */
`include "pdors_regs.vh"
module pdors_asserts (
   input wire clk,
   input wire rst_b,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire scan_end,
   input wire sync_start,
   input wire can_rx,
   input wire pdo_send,
   input wire retry_req,
   input wire [2:0] rate_sel,
   input wire bus_dominant,
   input wire link_up,
   input wire irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire acc = psel && penable;
   wire rate_wr = acc && pwrite && paddr == `PDORS_OFF_RATE;
   pready_high_a: assert property (pready) else $error("pready low");
   err_unmapped_a: assert property (acc && (paddr > `PDORS_OFF_LINK || paddr[1:0] != 2'h0) |-> pslverr)
      else $error("no error on unmapped access");
   err_quiet_a: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
   rd_idle_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0) else $error("prdata not zero");
   send_cause_a: assert property (pdo_send |-> $past(scan_end || sync_start))
      else $error("send without scan end or sync start");
   bus_level_a: assert property (rst_b && $past(rst_b) && $past(rst_b, 2) && $past(rst_b, 3)
      |-> bus_dominant == !$past(can_rx, 3)) else $error("bus level wrong");
   rate_write_a: assert property (rate_wr && pwdata <= 32'h5 |=> rate_sel == $past(pwdata[2:0]))
      else $error("rate not taken");
   rate_keep_a: assert property (rate_wr && pwdata > 32'h5 |=> $stable(rate_sel))
      else $error("bad rate accepted");
   reset_dflt_a: assert property (!$past(rst_b) |-> rate_sel == 3'h2 && link_up && !pdo_send && !irq)
      else $error("wrong state after reset");
   retry_pulse_a: assert property (retry_req |=> !retry_req) else $error("retry longer than a pulse");
endmodule

//--- verif/pdors_slave.sv
/* pdors_slave.sv: behavioural slave node on the far side of the link.
   Assumes clk of the scheduler; answers LAT cycles after the latest PDO, a new PDO restarting the wait. */
module pdors_slave #(
   parameter int LAT = 3
) (
   input wire clk,
   input wire pdo_send,
   input wire dom_req,
   output logic can_rx = 1'b1,
   output logic rx_ok = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   always @(posedge clk) begin
      // released bus floats recessive, read as 1
      can_rx <= !dom_req;
      rx_ok <= (cnt == 1);
      if (pdo_send)
         cnt <= LAT;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
endmodule

//--- verif/testbench.sv
/* testbench.sv: self-checking bench for pdors_top with a slave model.
   Assumes 100 MHz clk and APB register map of pdors_regs.vh. */
`include "pdors_regs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [11:0] a; logic [31:0] d;} pdors_row_t;
   pdors_row_t rows[8] = '{'{`PDORS_OFF_CTRL, 32'h3}, '{`PDORS_OFF_SYNC, 32'h2710},
      '{`PDORS_OFF_RATE, 32'h2}, '{`PDORS_OFF_TMO, 32'h64}, '{`PDORS_OFF_RETRY, 32'h3C},
      '{`PDORS_OFF_RECON, 32'h3C}, '{`PDORS_OFF_IRQ_MASK, 32'h0}, '{`PDORS_OFF_LINK, 32'h1}};
   logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, dom = 0;
   logic scan_end = 0, sync_start = 0, data_changed = 0, err;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, rd;
   wire [31:0] prdata;
   wire [2:0] rate_sel;
   wire pready, pslverr, rx_ok, can_rx, pdo_send, retry_req, bus_dominant, link_up, irq;
   int fails = 0, n_tests = 0;
   always #5 clk = ~clk;
   pdors_top pdors_top_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scan_end(scan_end), .sync_start(sync_start), .data_changed(data_changed), .rx_ok(rx_ok),
      .can_rx(can_rx), .pdo_send(pdo_send), .retry_req(retry_req), .rate_sel(rate_sel),
      .bus_dominant(bus_dominant), .link_up(link_up), .irq(irq));
   // slow answers, so a send overlaps later scans
   pdors_slave #(.LAT(40)) pdors_slave_inst (.clk(clk), .pdo_send(pdo_send), .dom_req(dom),
      .can_rx(can_rx), .rx_ok(rx_ok));
   // ====
   // tasks
   task results;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      #1;
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk) penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
      #1;
      if (i == 20) begin
         fails++;
         results;
      end
   endtask
   task wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
      apb(1, a, d);
      apb(0, a, 32'h0);
      chk(rd, exp);
   endtask
   task scan(input logic sy, input logic chg);
      @(posedge clk) {scan_end, sync_start, data_changed} <= {!sy, sy, chg};
      @(posedge clk) {scan_end, sync_start} <= 2'h0;
      #1;
   endtask
   // ====
   // sequence
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1;
      foreach (rows[i]) begin
         apb(0, rows[i].a, 32'h0);
         chk(rd, rows[i].d);
      end
      for (int c = 0; c < 7; c++) begin
         apb(1, `PDORS_OFF_RATE, c);
         chk(rate_sel, (c < 6) ? c : 5);
      end
      wr_rd(`PDORS_OFF_TMO, 32'hFA0, 32'hBB8);
      wr_rd(`PDORS_OFF_TMO, 32'h0, 32'h0);
      wr_rd(`PDORS_OFF_RETRY, 32'hFF, 32'hFF);
      wr_rd(`PDORS_OFF_RECON, 32'hFF, 32'hFF);
      apb(0, 12'h030, 32'h0);
      chk(err, 1);
      chk(rd, 32'h0);
      wr_rd(`PDORS_OFF_SYNC, 32'hA, 32'hA);
      apb(1, `PDORS_OFF_IRQ_STAT, 32'h1F);
      apb(1, `PDORS_OFF_IRQ_MASK, 32'h1);
      scan(1, 0);
      repeat (700) @(posedge clk);
      scan(0, 0);
      chk(pdo_send, 1);
      @(posedge clk);
      #1;
      chk(irq, 1);
      apb(1, `PDORS_OFF_IRQ_STAT, 32'h1);
      @(posedge clk);
      #1;
      chk(irq, 0);
      repeat (700) @(posedge clk);
      scan(0, 0);
      chk(pdo_send, 0);
      scan(1, 0);
      chk(pdo_send, 0);
      repeat (450) @(posedge clk);
      scan(0, 0);
      chk(pdo_send, 0);
      repeat (250) @(posedge clk);
      scan(1, 0);
      chk(pdo_send, 1);
      apb(1, `PDORS_OFF_IRQ_MASK, 32'h0);
      @(posedge clk);
      #1;
      chk(irq, 0);
      apb(0, `PDORS_OFF_IRQ_STAT, 32'h0);
      chk(rd[0], 1);
      apb(1, `PDORS_OFF_CTRL, 32'h2);
      scan(0, 1);
      chk(pdo_send, 1);
      scan(0, 0);
      chk(pdo_send, 0);
      apb(1, `PDORS_OFF_CTRL, 32'h0);
      scan(0, 1);
      chk(pdo_send, 0);
      dom <= 1;
      repeat (5) @(posedge clk);
      chk(bus_dominant, 1);
      dom <= 0;
      repeat (5) @(posedge clk);
      chk(bus_dominant, 0);
      chk(link_up, 1);
      @(posedge clk) rst_b <= 0;
      repeat (2) @(posedge clk);
      rst_b <= 1;
      apb(0, `PDORS_OFF_RATE, 32'h0);
      chk(rd, 32'h2);
      results;
   end
endmodule
bind pdors_top pdors_asserts pdors_asserts_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .scan_end(scan_end), .sync_start(sync_start), .can_rx(can_rx), .pdo_send(pdo_send),
   .retry_req(retry_req), .rate_sel(rate_sel), .bus_dominant(bus_dominant), .link_up(link_up), .irq(irq));
